//--- hdl/sli_consts.svh
`ifndef SLI_CONSTS_SVH
`define SLI_CONSTS_SVH

// Register byte offsets
`define SLI_OFF_CTRL 12'h000
`define SLI_OFF_STAT 12'h004
`define SLI_OFF_IRQ 12'h008
`define SLI_OFF_MASK 12'h00C
// Control fields
`define SLI_CTRL_MODE_LSB 0
`define SLI_CTRL_BOOT_BIT 4
`define SLI_CTRL_REBOOT_BIT 5
`define SLI_CTRL_MULTI_BIT 6
`define SLI_CTRL_RESET 32'h0000_0000
// Event bit positions
`define SLI_EV_FAULT 0
`define SLI_EV_STARTUP 1
// Timing in cycles at 100 MHz
`define SLI_CLK_MHZ 100
`define SLI_STARTUP_S 5
`define SLI_FLASH_ON_CYC 20000000
`define SLI_FLASH_OFF_CYC 20000000
`define SLI_GROUP_GAP_CYC 100000000
`define SLI_FAST_HALF_CYC 10000000
`define SLI_SLOW_HALF_CYC 50000000
`define SLI_PULSE_STRETCH_CYC 100000
`define SLI_FAULT_MAX 4'h8

`endif

//--- hdl/sli_pkg.sv
package sli_pkg;
    // Running modes of the controller core
    typedef enum logic [2:0] {
        SLI_MODE_OFF = 3'h0,
        SLI_MODE_CONT = 3'h1,
        SLI_MODE_EXT_TRIG = 3'h2,
        SLI_MODE_SW_TRIG = 3'h3,
        SLI_MODE_EXT_SW = 3'h4,
        SLI_MODE_INT_TRIG = 3'h5
    } sli_mode_t;
    // Fault flash sequencer states
    typedef enum logic [3:0] {
        SLI_FS_IDLE = 4'b0001,
        SLI_FS_ON = 4'b0010,
        SLI_FS_OFF = 4'b0100,
        SLI_FS_GAP = 4'b1000
    } sli_fstate_t;
endpackage : sli_pkg

//--- hdl/sli_status_led.sv
`timescale 1ns/1ps
`include "sli_consts.svh"
// Contract
// - Single-output error: green off, yellow flashes code
// - Normal: green on, yellow per mode
// - Fast yellow flash for external and software trigger modes
// - Slow yellow flash for switch/internal modes
// - Bootloader state flashes green
// - Boot data reception flashes yellow
// - Multi startup: power, strobe on, fault blinks
// - After startup indicators follow normal meanings
// - Reboot mode flashes fault and strobe together
// - Strobe lamp stretched per output pulse
// - Strobe steady in continuous current modes
// - Armed lamp lit while output voltage present
// - Link lamp on link, activity lamp flashes
// - Fault forces idle, output current stops
// - Fault codes one through eight
// - Groups repeat with code-count flashes
// - Latched fault code readable by host
module sli_status_led #(
    parameter int FLASH_ON = `SLI_FLASH_ON_CYC,
    parameter int FLASH_OFF = `SLI_FLASH_OFF_CYC,
    parameter int GROUP_GAP = `SLI_GROUP_GAP_CYC,
    parameter int FAST_HALF = `SLI_FAST_HALF_CYC,
    parameter int SLOW_HALF = `SLI_SLOW_HALF_CYC,
    parameter int STARTUP_CYC = `SLI_STARTUP_S * `SLI_CLK_MHZ * 1000000,
    parameter int PULSE_STRETCH = `SLI_PULSE_STRETCH_CYC
) (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, low
    input wire logic clk_en, // Freezes state when low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [3:0] fault_code_in, // Core fault code
    input wire logic fault_valid, // Core fault strobe
    input wire logic out_pulse, // Output pulse active
    input wire logic out_voltage, // Output voltage present
    input wire logic cfg_rx_active, // Config data receiving
    input wire logic eth_link, // Network link up
    input wire logic eth_activity, // Network traffic
    output logic force_idle, // Output shut down
    output logic led_green, // Single: green
    output logic led_yellow, // Single: yellow
    output logic led_power, // Multi: power
    output logic led_fault, // Multi: fault
    output logic led_strobe, // Multi: strobe
    output logic led_armed, // Multi: armed
    output logic led_link, // Network link lamp
    output logic led_activity, // Network activity lamp
    output logic irq // Level interrupt
);
    import sli_pkg::*;
    // ****************************************
    // Register bus
    // ****************************************
    logic [31:0] ctrl_q;
    logic [1:0] irq_stat_q;
    logic [1:0] irq_mask_q;
    logic [3:0] fault_q;
    logic startup_q;
    logic wr_en;
    logic startup_done_ev;
    logic fault_ev;
    sli_mode_t mode;
    logic boot_mode;
    logic reboot_mode;
    logic multi_mode;
    assign wr_en = psel && penable && pwrite && clk_en;
    assign pready = clk_en;
    assign mode = sli_mode_t'(ctrl_q[`SLI_CTRL_MODE_LSB +: 3]);
    assign boot_mode = ctrl_q[`SLI_CTRL_BOOT_BIT];
    assign reboot_mode = ctrl_q[`SLI_CTRL_REBOOT_BIT];
    assign multi_mode = ctrl_q[`SLI_CTRL_MULTI_BIT];
    // Unmapped addresses flag an error
    always_comb
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (paddr == `SLI_OFF_CTRL)
            prdata = ctrl_q;
        else if (paddr == `SLI_OFF_STAT)
            prdata = {26'h000_0000, startup_q, force_idle, fault_q};
        else if (paddr == `SLI_OFF_IRQ)
            prdata = {30'h0000_0000, irq_stat_q};
        else if (paddr == `SLI_OFF_MASK)
            prdata = {30'h0000_0000, irq_mask_q};
        else
        begin
            pslverr = psel && penable;
        end
    end
    // Control register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= `SLI_CTRL_RESET;
        else if (wr_en && paddr == `SLI_OFF_CTRL)
            ctrl_q <= {25'h000_0000, pwdata[6:0]};
    end
    // Mask register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_mask_q <= 2'h0;
        else if (wr_en && paddr == `SLI_OFF_MASK)
            irq_mask_q <= pwdata[1:0];
    end
    // Sticky events, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_stat_q <= 2'h0;
        else if (clk_en)
        begin
            irq_stat_q <= (irq_stat_q & ~((wr_en && paddr == `SLI_OFF_IRQ) ? pwdata[1:0] : 2'h0))
                | {startup_done_ev, fault_ev};
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);
    // ****************************************
    // Fault latch
    // ****************************************
    // First nonzero valid code latches and forces idle until reset
    assign fault_ev = fault_valid && !force_idle && fault_code_in != 4'h0
        && fault_code_in <= `SLI_FAULT_MAX;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_q <= 4'h0;
            force_idle <= 1'b0;
        end
        else if (clk_en && fault_ev)
        begin
            fault_q <= fault_code_in;
            force_idle <= 1'b1;
        end
    end
    // ****************************************
    // Startup timer
    // ****************************************
    logic [31:0] start_cnt_q;
    assign startup_done_ev = clk_en && startup_q && start_cnt_q == 32'(STARTUP_CYC - 1);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            start_cnt_q <= 32'h0000_0000;
            startup_q <= 1'b1;
        end
        else if (clk_en && startup_q)
        begin
            start_cnt_q <= start_cnt_q + 32'h0000_0001;
            if (startup_done_ev)
                startup_q <= 1'b0;
        end
    end
    // ****************************************
    // Blink generators
    // ****************************************
    logic [31:0] fast_cnt_q;
    logic [31:0] slow_cnt_q;
    logic fast_q;
    logic slow_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fast_cnt_q <= 32'h0000_0000;
            fast_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (fast_cnt_q == 32'(FAST_HALF - 1))
            begin
                fast_cnt_q <= 32'h0000_0000;
                fast_q <= !fast_q;
            end
            else
                fast_cnt_q <= fast_cnt_q + 32'h0000_0001;
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slow_cnt_q <= 32'h0000_0000;
            slow_q <= 1'b0;
        end
        else if (clk_en)
        begin
            if (slow_cnt_q == 32'(SLOW_HALF - 1))
            begin
                slow_cnt_q <= 32'h0000_0000;
                slow_q <= !slow_q;
            end
            else
                slow_cnt_q <= slow_cnt_q + 32'h0000_0001;
        end
    end
    // ****************************************
    // Fault flash sequencer
    // ****************************************
    sli_fstate_t fs_q;
    logic [31:0] fs_cnt_q;
    logic [3:0] flash_idx_q;
    logic fault_lamp;
    assign fault_lamp = (fs_q == SLI_FS_ON);
    // Groups of fault_q flashes separated by a long gap
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fs_q <= SLI_FS_IDLE;
            fs_cnt_q <= 32'h0000_0000;
            flash_idx_q <= 4'h0;
        end
        else if (clk_en)
        begin
            case (fs_q)
                SLI_FS_IDLE:
                begin
                    fs_cnt_q <= 32'h0000_0000;
                    flash_idx_q <= 4'h0;
                    if (fault_q != 4'h0)
                        fs_q <= SLI_FS_ON;
                end
                SLI_FS_ON:
                begin
                    if (fs_cnt_q == 32'(FLASH_ON - 1))
                    begin
                        fs_cnt_q <= 32'h0000_0000;
                        flash_idx_q <= flash_idx_q + 4'h1;
                        if (flash_idx_q + 4'h1 == fault_q)
                            fs_q <= SLI_FS_GAP;
                        else
                            fs_q <= SLI_FS_OFF;
                    end
                    else
                        fs_cnt_q <= fs_cnt_q + 32'h0000_0001;
                end
                SLI_FS_OFF:
                begin
                    if (fs_cnt_q == 32'(FLASH_OFF - 1))
                    begin
                        fs_cnt_q <= 32'h0000_0000;
                        fs_q <= SLI_FS_ON;
                    end
                    else
                        fs_cnt_q <= fs_cnt_q + 32'h0000_0001;
                end
                SLI_FS_GAP:
                begin
                    if (fs_cnt_q == 32'(GROUP_GAP - 1))
                    begin
                        fs_cnt_q <= 32'h0000_0000;
                        flash_idx_q <= 4'h0;
                        fs_q <= SLI_FS_ON;
                    end
                    else
                        fs_cnt_q <= fs_cnt_q + 32'h0000_0001;
                end
                default:
                    fs_q <= SLI_FS_IDLE;
            endcase
        end
    end
    // ****************************************
    // Pulse stretcher
    // ****************************************
    logic [31:0] pulse_cnt_q;
    logic pulse_lamp;
    assign pulse_lamp = out_pulse || pulse_cnt_q != 32'h0000_0000;
    // Lamp tracks pulse length plus a minimum visible time
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pulse_cnt_q <= 32'h0000_0000;
        else if (clk_en)
        begin
            if (out_pulse && !force_idle)
                pulse_cnt_q <= 32'(PULSE_STRETCH);
            else if (pulse_cnt_q != 32'h0000_0000)
                pulse_cnt_q <= pulse_cnt_q - 32'h0000_0001;
        end
    end
    // ****************************************
    // Lamp outputs
    // ****************************************
    logic cont_mode;
    assign cont_mode = (mode == SLI_MODE_CONT) || (mode == SLI_MODE_EXT_SW);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            led_green <= 1'b0;
            led_yellow <= 1'b0;
            led_power <= 1'b0;
            led_fault <= 1'b0;
            led_strobe <= 1'b0;
            led_armed <= 1'b0;
            led_link <= 1'b0;
            led_activity <= 1'b0;
        end
        else if (clk_en)
        begin
            led_link <= eth_link;
            led_activity <= eth_activity && fast_q;
            // Single-output lamp pair
            if (force_idle)
            begin
                led_green <= 1'b0;
                led_yellow <= fault_lamp;
            end
            else if (boot_mode)
            begin
                led_green <= slow_q;
                led_yellow <= cfg_rx_active && fast_q;
            end
            else
            begin
                led_green <= 1'b1;
                case (mode)
                    SLI_MODE_CONT: led_yellow <= 1'b1;
                    SLI_MODE_EXT_TRIG, SLI_MODE_SW_TRIG: led_yellow <= fast_q;
                    SLI_MODE_EXT_SW, SLI_MODE_INT_TRIG: led_yellow <= slow_q;
                    default: led_yellow <= 1'b0;
                endcase
            end
            // Multi-channel lamp set
            led_power <= multi_mode;
            if (!multi_mode)
            begin
                led_fault <= 1'b0;
                led_strobe <= 1'b0;
                led_armed <= 1'b0;
            end
            else if (startup_q)
            begin
                led_fault <= fast_q;
                led_strobe <= 1'b1;
                led_armed <= 1'b0;
            end
            else if (reboot_mode)
            begin
                led_fault <= fast_q;
                led_strobe <= fast_q;
                led_armed <= 1'b0;
            end
            else
            begin
                led_fault <= fault_lamp;
                led_strobe <= !force_idle && (cont_mode || pulse_lamp);
                led_armed <= !force_idle && out_voltage;
            end
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    AST_FAULT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && fault_ev |=> force_idle && fault_q == $past(fault_code_in))
        else $error("fault did not force idle");
    AST_FAULT_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        force_idle |=> force_idle && $stable(fault_q)) else $error("fault latch changed");
    AST_ERR_GREEN: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && force_idle |=> !led_green) else $error("green lit in error");
    AST_NORMAL_CONT: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !force_idle && !boot_mode && mode == SLI_MODE_CONT |=> led_green && led_yellow)
        else $error("continuous lamps wrong");
    AST_FAST_YEL: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !force_idle && !boot_mode && mode == SLI_MODE_SW_TRIG
        |=> led_yellow == $past(fast_q)) else $error("fast flash wrong");
    AST_SLOW_YEL: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !force_idle && !boot_mode && mode == SLI_MODE_INT_TRIG
        |=> led_yellow == $past(slow_q)) else $error("slow flash wrong");
    AST_ZERO_DARK: assert property (@(posedge pclk) disable iff (!presetn)
        fault_q == 4'h0 |-> fs_q == SLI_FS_IDLE) else $error("code zero flashing");
    AST_GROUP_COUNT: assert property (@(posedge pclk) disable iff (!presetn)
        fs_q == SLI_FS_GAP |-> flash_idx_q == fault_q) else $error("flash count mismatch");
    AST_ARMED: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && multi_mode && !startup_q && !reboot_mode && !force_idle && out_voltage
        |=> led_armed) else $error("armed lamp dark");
endmodule : sli_status_led

//--- verification/sli_led_panel.sv
`timescale 1ns/1ps
// ****************
// Front panel lamp model
// ****************
module sli_led_panel (
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, low
    input wire logic clr, // Zero all counters
    input wire logic led_green, // Green lamp
    input wire logic led_yellow, // Yellow lamp
    input wire logic led_fault, // Fault lamp
    input wire logic led_strobe, // Strobe lamp
    input wire logic led_activity, // Activity lamp
    output logic [7:0] n_green, // Green flashes
    output logic [7:0] n_yellow, // Yellow flashes
    output logic [7:0] n_fault, // Fault flashes
    output logic [7:0] n_strobe, // Strobe flashes
    output logic [7:0] n_act // Activity flashes
);
    logic [4:0] lamp;
    logic [4:0] lit_q;
    logic [7:0] cnt_q [5];
    // Lamps as the eye sees them
    assign lamp = {led_activity, led_strobe, led_fault, led_yellow, led_green};
    // Each turn-on counts as one flash
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lit_q <= '0;
            cnt_q <= '{default: '0};
        end
        else
        begin
            lit_q <= lamp;
            for (int i = 0; i < 5; i++)
            begin
                if (clr)
                    cnt_q[i] <= '0;
                else if (lamp[i] && !lit_q[i])
                    cnt_q[i] <= cnt_q[i] + 8'h01;
            end
        end
    end
    // Counter outputs
    assign n_green = cnt_q[0];
    assign n_yellow = cnt_q[1];
    assign n_fault = cnt_q[2];
    assign n_strobe = cnt_q[3];
    assign n_act = cnt_q[4];
endmodule : sli_led_panel

//--- verification/sli_testbench.sv
`timescale 1ns/1ps
`include "sli_consts.svh"
// ****************
// Status lamp testbench
// ****************
module testbench;
    import sli_pkg::*;
    localparam int ON = 4;
    localparam int OFF = 4;
    localparam int GAP = 16;
    localparam int FH = 2;
    localparam int SH = 8;
    localparam int PS = 3;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, clr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] fault_code_in;
    logic fault_valid, out_pulse, out_voltage, cfg_rx_active, eth_link, eth_activity;
    logic force_idle, led_green, led_yellow, led_power, led_fault, led_strobe;
    logic led_armed, led_link, led_activity, irq, serr;
    logic [7:0] n_green, n_yellow, n_fault, n_strobe, n_act;
    int bad_count, num_checks;
    // Design under test with short timings
    sli_status_led #(.FLASH_ON(ON), .FLASH_OFF(OFF), .GROUP_GAP(GAP), .FAST_HALF(FH),
        .SLOW_HALF(SH), .STARTUP_CYC(50), .PULSE_STRETCH(PS)) DUT (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_code_in(fault_code_in), .fault_valid(fault_valid),
        .out_pulse(out_pulse), .out_voltage(out_voltage), .cfg_rx_active(cfg_rx_active),
        .eth_link(eth_link), .eth_activity(eth_activity), .force_idle(force_idle),
        .led_green(led_green), .led_yellow(led_yellow), .led_power(led_power),
        .led_fault(led_fault), .led_strobe(led_strobe), .led_armed(led_armed),
        .led_link(led_link), .led_activity(led_activity), .irq(irq));
    // Lamp panel
    sli_led_panel PANEL (.pclk(pclk), .presetn(presetn), .clr(clr), .led_green(led_green),
        .led_yellow(led_yellow), .led_fault(led_fault), .led_strobe(led_strobe),
        .led_activity(led_activity), .n_green(n_green), .n_yellow(n_yellow),
        .n_fault(n_fault), .n_strobe(n_strobe), .n_act(n_act));
    // ****************
    // Helpers
    // ****************
    task automatic final_report;
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc
    // One APB transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            bad_count++;
            final_report();
        end
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask : apb
    task automatic flashes(input int n);
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        cyc(n);
    endtask : flashes
    task automatic do_reset;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
    endtask : do_reset
    task automatic fault_in(input logic [3:0] c);
        @(posedge pclk);
        fault_code_in <= c;
        fault_valid <= 1'b1;
        @(posedge pclk);
        fault_valid <= 1'b0;
        cyc(1);
    endtask : fault_in
    // ****************
    // Scenarios
    // ****************
    task automatic t_startup;
        int n;
        apb(0, `SLI_OFF_CTRL, 0);
        chk(rdat, 32'h0000_0000);
        apb(0, `SLI_OFF_MASK, 0);
        chk(rdat, 32'h0000_0000);
        apb(1, `SLI_OFF_CTRL, 32'h0000_0040);
        apb(1, `SLI_OFF_MASK, 32'h0000_0003);
        apb(0, `SLI_OFF_STAT, 0);
        chk(rdat, 32'h0000_0020);
        flashes(16);
        chk(n_fault, 16 / (2 * FH));
        chk({led_power, led_strobe, n_strobe}, {2'b11, 8'h00});
        n = 0;
        while (irq !== 1'b1 && n < 100)
        begin
            cyc(1);
            n++;
        end
        if (irq !== 1'b1)
        begin
            bad_count++;
            final_report();
        end
        cyc(3);
        chk({led_power, led_strobe, led_fault}, 3'b100);
        apb(0, `SLI_OFF_IRQ, 0);
        chk(rdat, 32'h0000_0002);
        apb(1, `SLI_OFF_IRQ, 32'h0000_0002);
        chk(irq, 1'b0);
        $display("startup test done");
    endtask : t_startup
    task automatic t_regs;
        apb(1, `SLI_OFF_CTRL, 32'hFFFF_FFFF);
        apb(1, 12'h010, 32'h0000_0000);
        apb(0, `SLI_OFF_CTRL, 0);
        chk(rdat, 32'h0000_007F);
        apb(0, 12'h010, 0);
        chk({serr, rdat}, {1'b1, 32'h0000_0000});
        apb(1, `SLI_OFF_CTRL, 32'h0000_0000);
        @(posedge pclk);
        clk_en <= 1'b0;
        cyc(1);
        chk(pready, 1'b0);
        @(posedge pclk);
        clk_en <= 1'b1;
        $display("register test done");
    endtask : t_regs
    task automatic t_modes;
        int rises [6] = '{0, 0, 80 / (2 * FH), 80 / (2 * FH), 80 / (2 * SH), 80 / (2 * SH)};
        for (int m = 0; m < 6; m++)
        begin
            apb(1, `SLI_OFF_CTRL, m);
            cyc(20);
            if (m < 2)
                chk(led_yellow, m);
            flashes(80);
            chk(n_yellow, rises[m]);
            chk({led_green, n_green}, {1'b1, 8'h00});
            apb(1, `SLI_OFF_CTRL, 32'h0000_0040 | m);
            cyc(4);
            chk(led_strobe, m == 1 || m == 4);
        end
        $display("mode test done");
    endtask : t_modes
    task automatic t_boot;
        apb(1, `SLI_OFF_CTRL, 32'h0000_0010);
        flashes(80);
        chk({n_green, n_yellow}, {8'(80 / (2 * SH)), 8'h00});
        @(posedge pclk);
        cfg_rx_active <= 1'b1;
        flashes(80);
        chk(n_yellow, 80 / (2 * FH));
        @(posedge pclk);
        cfg_rx_active <= 1'b0;
        $display("boot test done");
    endtask : t_boot
    task automatic t_multi;
        int h;
        apb(1, `SLI_OFF_CTRL, 32'h0000_0040);
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge pclk);
            out_voltage <= v;
            cyc(3);
            chk(led_armed, v);
        end
        for (int w = 1; w < 8; w += 5)
        begin
            @(posedge pclk);
            out_pulse <= 1'b1;
            h = 0;
            // Count lit cycles from pulse start to well after its end
            for (int k = 1; k <= 15; k++)
            begin
                @(posedge pclk);
                if (k == w)
                    out_pulse <= 1'b0;
                #1;
                h += led_strobe;
            end
            chk(h >= w + PS && h <= w + PS + 1, 1);
        end
        apb(1, `SLI_OFF_CTRL, 32'h0000_0060);
        cyc(8);
        flashes(40);
        chk({n_fault, n_strobe}, {8'(40 / (2 * FH)), 8'(40 / (2 * FH))});
        repeat (6)
        begin
            cyc(1);
            chk(led_fault, led_strobe);
        end
        for (int v = 1; v >= 0; v--)
        begin
            @(posedge pclk);
            eth_link <= v;
            eth_activity <= v;
            cyc(3);
            flashes(40);
            chk({led_link, n_act}, {1'(v), 8'(v * 40 / (2 * FH))});
        end
        $display("multi test done");
    endtask : t_multi
    task automatic t_fault;
        for (int c = 1; c <= 8; c++)
        begin
            do_reset();
            apb(1, `SLI_OFF_CTRL, 32'h0000_0001);
            fault_in(4'h0);
            fault_in(4'h9);
            chk(force_idle, 1'b0);
            fault_in(4'(c));
            chk(force_idle, 1'b1);
            fault_in(c == 8 ? 4'h1 : 4'h8);
            apb(0, `SLI_OFF_STAT, 0);
            chk(rdat[4:0], {1'b1, 4'(c)});
            cyc(4);
            flashes(2 * (c * ON + (c - 1) * OFF + GAP));
            chk(n_yellow, 2 * c);
            chk({led_green, n_green, force_idle}, {1'b0, 8'h00, 1'b1});
            if (c == 3)
            begin
                apb(0, `SLI_OFF_IRQ, 0);
                chk({irq, rdat[0]}, 2'b01);
                apb(1, `SLI_OFF_MASK, 32'h0000_0001);
                chk(irq, 1'b1);
                apb(1, `SLI_OFF_IRQ, 32'h0000_0001);
                chk(irq, 1'b0);
            end
        end
        do_reset();
        cyc(2);
        chk({force_idle, led_yellow}, 2'b00);
        $display("fault test done");
    endtask : t_fault
    // ****************
    // Clock, watchdog and main sequence
    // ****************
    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    initial
    begin
        repeat (100000) @(posedge pclk);
        bad_count++;
        final_report();
    end
    initial
    begin
        {presetn, psel, penable, pwrite, clr, fault_valid, out_pulse} = '0;
        {out_voltage, cfg_rx_active, eth_link, eth_activity} = '0;
        clk_en = 1'b1;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        fault_code_in = 4'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_startup();
        t_regs();
        t_modes();
        t_boot();
        t_multi();
        t_fault();
        final_report();
    end
endmodule : testbench
